// file: shared/mcs_pkg.sv
// shared constants for the modulator carrier select block
package mcs_pkg;
    localparam int ADDR_W = 4;
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_HIGH_CARRIER = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_LOW_CARRIER  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MOD_CONTROL  = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MOD_SOURCE   = 4'hC;
    // carrier register fields
    localparam int BIT_PIN_DISABLE = 7;
    localparam int BIT_INVERT      = 6;
    localparam int BIT_SYNC        = 5;
    localparam int SEL_MSB         = 3;
    localparam logic [7:0] CARRIER_WMASK = 8'hEF;
    // modulation control fields
    localparam int BIT_ENABLE      = 7;
    localparam int BIT_PIN_OE      = 6;
    localparam int BIT_SLEW        = 5;
    localparam int BIT_OUT_INVERT  = 4;
    localparam int BIT_OUT_VALUE   = 3;
    localparam int BIT_SW_MOD      = 0;
    localparam logic [7:0] CONTROL_WMASK = 8'hF1;
    localparam logic [7:0] SOURCE_WMASK  = 8'h8F;
    // reset values
    localparam logic [7:0] RST_CARRIER = 8'h00;
    localparam logic [7:0] RST_CONTROL = 8'h20;
    localparam logic [7:0] RST_SOURCE  = 8'h00;
    // carrier select codes
    localparam logic [3:0] SEL_GROUND  = 4'h0;
    localparam logic [3:0] SEL_PIN_ONE = 4'h1;
    localparam logic [3:0] SEL_PIN_TWO = 4'h2;
    localparam logic [3:0] SEL_REFCLK  = 4'h3;
    localparam logic [3:0] SEL_PWM_1   = 4'h4;
    localparam logic [3:0] SEL_PWM_4   = 4'h7;
    // modulation source codes and axi4-lite response codes
    localparam logic [3:0] MSRC_SW_BIT = 4'h0;
    localparam logic [3:0] MSRC_PIN    = 4'h1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: logic/mcs_carrier_select.sv
// one carrier source selector with polarity and pin release
`timescale 1ns/10ps
module mcs_carrier_select (
    input  wire logic [7:0] ctrl,
    input  wire logic       pin_one,
    input  wire logic       pin_two,
    input  wire logic       ref_clk,
    input  wire logic [3:0] pwm_out,
    input  wire logic [3:0] pwm_mode,
    output logic            carrier,
    output logic [5:0]      pin_release
);
    wire [3:0] sel      = ctrl[mcs_pkg::SEL_MSB:0];
    wire       reserved = sel[3];
    logic      raw;
    logic [5:0] onehot;

    always_comb begin
        raw = 1'b0;
        // (R1) low codes route ground, pins, ref clock
        // (R2) pwm codes only in pwm output mode
        case (sel)
            mcs_pkg::SEL_GROUND:  raw = 1'b0;
            mcs_pkg::SEL_PIN_ONE: raw = pin_one;
            mcs_pkg::SEL_PIN_TWO: raw = pin_two;
            mcs_pkg::SEL_REFCLK:  raw = ref_clk;
            default: begin
                // (R4) reserved codes connect nothing
                // (R15) reserved codes give zero
                if (!reserved) begin
                    raw = pwm_out[sel[1:0]] & pwm_mode[sel[1:0]];
                end
            end
        endcase
    end

    // (R5) polarity after selection
    assign carrier = raw ^ ctrl[mcs_pkg::BIT_INVERT];

    // pin release: index 0..3 pwm units, 4 ref clock, 5 unused
    always_comb begin
        onehot = 6'h00;
        if (sel == mcs_pkg::SEL_REFCLK) begin
            onehot[4] = 1'b1;
        end else if (sel >= mcs_pkg::SEL_PWM_1 && sel <= mcs_pkg::SEL_PWM_4) begin
            onehot[sel[1:0]] = 1'b1;
        end
    end
    // (R10) release chosen source pin
    assign pin_release = ctrl[mcs_pkg::BIT_PIN_DISABLE] ? onehot : 6'h00;
endmodule

// file: logic/mcs_carrier_switch.sv
// modulator mixing with optional falling-edge synchronised switch
`timescale 1ns/10ps
module mcs_carrier_switch (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic enable,
    input  wire logic mod_sig,
    input  wire logic high_car,
    input  wire logic low_car,
    input  wire logic high_sync,
    input  wire logic low_sync,
    output logic      mixed,
    output logic      using_high
);
    logic use_high_q, use_high_d;
    logic high_prev_q, low_prev_q;
    wire  high_fall = high_prev_q & ~high_car;
    wire  low_fall  = low_prev_q & ~low_car;

    always_comb begin
        use_high_d = use_high_q;
        if (mod_sig != use_high_q) begin
            // (R7) wait for high carrier falling edge
            if (use_high_q) begin
                use_high_d = (high_sync && !high_fall);
            // (R8) wait for low carrier falling edge
            end else begin
                use_high_d = !(low_sync && !low_fall);
            end
        end
        // while disabled follow the modulation at once
        if (!enable) begin
            use_high_d = mod_sig;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            use_high_q  <= 1'b0;
            high_prev_q <= 1'b0;
            low_prev_q  <= 1'b0;
        end else begin
            use_high_q  <= use_high_d;
            high_prev_q <= high_car;
            low_prev_q  <= low_car;
        end
    end

    // (R13) high carrier while modulator high
    // (R14) disabled gives no output
    assign mixed      = enable & (use_high_q ? high_car : low_car);
    assign using_high = use_high_q;

    // (R7) switch away only on high falling edge
    sync_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && high_sync && use_high_q && !mod_sig && !high_fall |=> use_high_q)
        else $error("high carrier left without falling edge");
    // (R8) switch away only on low falling edge
    sync_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && low_sync && !use_high_q && mod_sig && !low_fall |=> !use_high_q)
        else $error("low carrier left without falling edge");
    // (R9) unsynchronised switch away from the high carrier in one cycle
    nosync_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !high_sync && use_high_q && !mod_sig |=> !use_high_q)
        else $error("high carrier not left at once");
endmodule

// file: logic/mcs_top.sv
// carrier select front end of the data signal modulator with axi4-lite registers
// Function
// (R1) High selector codes 0000-0011 route ground, carrier pin one, carrier pin two and reference clock.
// (R2) High selector codes 0100-0111 route pwm units one to four, only while each is in pwm mode.
// (R3) The low selector in bits 3:0 uses the same code assignment as the high selector.
// (R4) Selector codes 1000-1111 are reserved and connect no source.
// (R5) High carrier invert bit 6 inverts the selected high carrier.
// (R6) Low carrier invert bit 6 inverts the selected low carrier.
// (R7) With high sync bit 5 set, leaving the high carrier waits for its falling edge.
// (R8) With low sync bit 5 set, leaving the low carrier waits for its falling edge.
// (R9) With sync clear the switch away from a carrier happens at once.
// (R10) High carrier bit 7 releases the chosen high source from its own pin.
// (R11) Low carrier bit 7 releases the chosen low source from its own pin.
// (R12) Bit 4 of carrier registers and all unused bits read zero.
// (R13) Output takes the high carrier while modulation is one, else the low carrier.
// (R14) With the module enable clear nothing is mixed and the output is zero.
// (R15) A reserved selector code gives a zero carrier before inversion.
`timescale 1ns/10ps
module mcs_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // carrier sources
    input  wire logic        carrier_input_pin_one,
    input  wire logic        carrier_input_pin_two,
    input  wire logic        reference_clock_signal,
    input  wire logic [3:0]  pwm_unit_output,
    input  wire logic [3:0]  pwm_unit_pwm_mode,
    // modulation signal from the source selector outside
    input  wire logic        modulation_signal,
    // outputs
    output logic             mixed_output,
    output logic             conditioned_high_carrier,
    output logic             conditioned_low_carrier,
    output logic [5:0]       source_pin_release,
    output logic [3:0]       modulation_source_select,
    output logic             modulation_source_pin_disable,
    output logic             modulator_pin_output_enable,
    output logic             output_slew_limit,
    output logic             output_invert
);
    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [7:0]  high_carrier_control_q;
    logic [7:0]  low_carrier_control_q;
    logic [7:0]  modulation_control_q;
    logic [7:0]  modulation_source_control_q;

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [3:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;

    wire aw_take   = s_axi_awvalid && !aw_held_q && !bvalid_q;
    wire w_take    = s_axi_wvalid && !w_held_q && !bvalid_q;
    wire aw_have   = aw_held_q || aw_take;
    wire w_have    = w_held_q || w_take;
    wire wr_fire   = aw_have && w_have && !bvalid_q;
    wire [3:0]  wr_addr = aw_held_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? w_data_q : s_axi_wdata;
    wire        wr_lane = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];
    wire [7:0]  wr_byte = wr_data[7:0];

    wire wr_high   = wr_fire && wr_lane && wr_addr == mcs_pkg::OFS_HIGH_CARRIER;
    wire wr_low    = wr_fire && wr_lane && wr_addr == mcs_pkg::OFS_LOW_CARRIER;
    wire wr_ctrl   = wr_fire && wr_lane && wr_addr == mcs_pkg::OFS_MOD_CONTROL;
    wire wr_src    = wr_fire && wr_lane && wr_addr == mcs_pkg::OFS_MOD_SOURCE;
    wire wr_mapped = wr_addr == mcs_pkg::OFS_HIGH_CARRIER || wr_addr == mcs_pkg::OFS_LOW_CARRIER
                  || wr_addr == mcs_pkg::OFS_MOD_CONTROL || wr_addr == mcs_pkg::OFS_MOD_SOURCE;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            aw_held_q <= aw_have && !wr_fire;
            w_held_q  <= w_have && !wr_fire;
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= mcs_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? mcs_pkg::RESP_OKAY : mcs_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_carrier_control_q      <= mcs_pkg::RST_CARRIER;
            low_carrier_control_q       <= mcs_pkg::RST_CARRIER;
            modulation_control_q        <= mcs_pkg::RST_CONTROL;
            modulation_source_control_q <= mcs_pkg::RST_SOURCE;
        end else begin
            // (R12) unimplemented bits never stored
            if (wr_high) begin
                high_carrier_control_q <= wr_byte & mcs_pkg::CARRIER_WMASK;
            end
            if (wr_low) begin
                low_carrier_control_q <= wr_byte & mcs_pkg::CARRIER_WMASK;
            end
            if (wr_ctrl) begin
                modulation_control_q <= wr_byte & mcs_pkg::CONTROL_WMASK;
            end
            if (wr_src) begin
                modulation_source_control_q <= wr_byte & mcs_pkg::SOURCE_WMASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // carrier path
    // ----------------------------------------------------------------
    logic       high_car;
    logic       low_car;
    logic [5:0] high_release;
    logic [5:0] low_release;
    logic       mixed;
    logic       using_high;

    mcs_carrier_select u_high (
        .ctrl        (high_carrier_control_q),
        .pin_one     (carrier_input_pin_one),
        .pin_two     (carrier_input_pin_two),
        .ref_clk     (reference_clock_signal),
        .pwm_out     (pwm_unit_output),
        .pwm_mode    (pwm_unit_pwm_mode),
        .carrier     (high_car),
        .pin_release (high_release)
    );

    // (R3) low selector shares the code map
    // (R6) low polarity applied inside selector
    // (R11) low source pin release
    mcs_carrier_select u_low (
        .ctrl        (low_carrier_control_q),
        .pin_one     (carrier_input_pin_one),
        .pin_two     (carrier_input_pin_two),
        .ref_clk     (reference_clock_signal),
        .pwm_out     (pwm_unit_output),
        .pwm_mode    (pwm_unit_pwm_mode),
        .carrier     (low_car),
        .pin_release (low_release)
    );

    wire enable   = modulation_control_q[mcs_pkg::BIT_ENABLE];
    wire src_sw   = modulation_source_control_q[3:0] == mcs_pkg::MSRC_SW_BIT;
    // software bit drives the modulation when selected, otherwise the outside source
    wire mod_sig  = src_sw ? modulation_control_q[mcs_pkg::BIT_SW_MOD] : modulation_signal;

    mcs_carrier_switch u_switch (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .enable     (enable),
        .mod_sig    (mod_sig),
        .high_car   (high_car),
        .low_car    (low_car),
        .high_sync  (high_carrier_control_q[mcs_pkg::BIT_SYNC]),
        .low_sync   (low_carrier_control_q[mcs_pkg::BIT_SYNC]),
        .mixed      (mixed),
        .using_high (using_high)
    );

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    logic mixed_q;
    logic high_car_q;
    logic low_car_q;
    logic [5:0] release_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mixed_q    <= 1'b0;
            high_car_q <= 1'b0;
            low_car_q  <= 1'b0;
            release_q  <= 6'h00;
        end else begin
            // (R14) no output while disabled
            mixed_q    <= mixed;
            high_car_q <= high_car;
            low_car_q  <= low_car;
            // (R10) released pins of either chosen source
            release_q  <= high_release | low_release;
        end
    end

    assign mixed_output                  = mixed_q;
    assign conditioned_high_carrier      = high_car_q;
    assign conditioned_low_carrier       = low_car_q;
    assign source_pin_release            = release_q;
    assign modulation_source_select      = modulation_source_control_q[3:0];
    assign modulation_source_pin_disable = modulation_source_control_q[7];
    assign modulator_pin_output_enable   = modulation_control_q[mcs_pkg::BIT_PIN_OE];
    assign output_slew_limit             = modulation_control_q[mcs_pkg::BIT_SLEW];
    assign output_invert                 = modulation_control_q[mcs_pkg::BIT_OUT_INVERT];

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    wire  rd_take = s_axi_arvalid && !rvalid_q;
    // output status bit shows the mixer's current value
    wire [7:0] ctrl_view = modulation_control_q | {4'h0, mixed_q, 3'h0};
    logic [7:0] rd_byte;
    logic       rd_ok;

    always_comb begin
        rd_byte = 8'h00;
        rd_ok   = 1'b1;
        // (R12) unused bits read zero
        case (s_axi_araddr)
            mcs_pkg::OFS_HIGH_CARRIER: rd_byte = high_carrier_control_q;
            mcs_pkg::OFS_LOW_CARRIER:  rd_byte = low_carrier_control_q;
            mcs_pkg::OFS_MOD_CONTROL:  rd_byte = ctrl_view;
            mcs_pkg::OFS_MOD_SOURCE:   rd_byte = modulation_source_control_q;
            default:                   rd_ok   = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= mcs_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= rd_ok ? mcs_pkg::RESP_OKAY : mcs_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // (R14) disabled output stays low
    disabled_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable |=> !mixed_output)
        else $error("output active while disabled");
    // (R4) reserved code gives only the invert value
    reserved_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        high_carrier_control_q[3] |=> conditioned_high_carrier == $past(high_carrier_control_q[6]))
        else $error("reserved high code passed a source");
    // (R15) reserved low code is zero before invert
    reserved_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        low_carrier_control_q[3] |=> conditioned_low_carrier == $past(low_carrier_control_q[6]))
        else $error("reserved low code passed a source");
    // (R1) ground code yields invert value
    ground_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
        high_carrier_control_q[3:0] == 4'h0 |=> conditioned_high_carrier == $past(high_carrier_control_q[6]))
        else $error("ground code not zero");
    // (R12) bit 4 reads zero except at the modulation control offset
    bit_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid |-> !s_axi_rdata[4] || s_axi_rresp != mcs_pkg::RESP_OKAY
            || $past(s_axi_araddr) == mcs_pkg::OFS_MOD_CONTROL)
        else $error("unimplemented bit read as one");
    // (R13) enabled output follows high carrier while it is chosen
    mix_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
        enable && using_high |=> mixed_output == $past(high_car))
        else $error("output not high carrier");
endmodule

// file: bench/mcs_source_model.sv
// behavioural model of the pwm units, reference clock and carrier pins
`timescale 1ns/10ps
module mcs_source_model (
    input  wire logic aclk,
    input  wire logic full_mode,
    output logic       pin_one = 1'h0,
    output logic       pin_two = 1'h0,
    output logic       ref_clk = 1'h0,
    output logic [3:0] pwm_out = 4'h0,
    output logic [3:0] pwm_mode = 4'hF
);
    // ----------------------------------------
    // free running sources
    // ----------------------------------------
    always @(posedge aclk) begin
        pin_one <= 1'($urandom);
        pin_two <= 1'($urandom);
        ref_clk <= ~ref_clk;
        pwm_out <= 4'($urandom);
        // idle units test the pwm gate
        pwm_mode <= full_mode ? 4'hF : 4'($urandom);
    end
endmodule

// file: bench/mcs_top_test.sv
// self-checking bench for the carrier select front end
`timescale 1ns/10ps
module mcs_top_test;
    logic        aclk = 1'h0, aresetn = 1'h0, full_mode = 1'h1, modulation_signal = 1'h0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        carrier_input_pin_one, carrier_input_pin_two, reference_clock_signal;
    logic [3:0]  pwm_unit_output, pwm_unit_pwm_mode, modulation_source_select;
    logic        mixed_output, conditioned_high_carrier, conditioned_low_carrier;
    logic [5:0]  source_pin_release;
    logic        modulation_source_pin_disable, modulator_pin_output_enable;
    logic        output_slew_limit, output_invert;
    logic [7:0]  hi_q = 8'h00, lo_q = 8'h00, v, r;
    logic [5:0]  er = 6'h00;
    logic        eh = 1'h0, el = 1'h0, ok_r = 1'h0, busy = 1'h1;
    int          bad_count = 0, check_count = 0, quiet = 0;

    mcs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .carrier_input_pin_one, .carrier_input_pin_two,
        .reference_clock_signal, .pwm_unit_output, .pwm_unit_pwm_mode, .modulation_signal,
        .mixed_output, .conditioned_high_carrier, .conditioned_low_carrier, .source_pin_release,
        .modulation_source_select, .modulation_source_pin_disable, .modulator_pin_output_enable,
        .output_slew_limit, .output_invert);
    mcs_source_model src_u (.aclk, .full_mode, .pin_one(carrier_input_pin_one),
        .pin_two(carrier_input_pin_two), .ref_clk(reference_clock_signal),
        .pwm_out(pwm_unit_output), .pwm_mode(pwm_unit_pwm_mode));

    initial forever #50 aclk = ~aclk;

    // ----------------------------------------
    // reference carrier and pin release
    // ----------------------------------------
    function automatic logic car(input logic [7:0] c);
        logic [3:0] fix;
        fix = {reference_clock_signal, carrier_input_pin_two, carrier_input_pin_one, 1'h0};
        if (c[3])
            return c[6];
        return c[6] ^ (c[2] ? pwm_unit_output[c[1:0]] & pwm_unit_pwm_mode[c[1:0]] : fix[c[1:0]]);
    endfunction

    function automatic logic [5:0] rel(input logic [7:0] c);
        logic [5:0] m;
        m = 6'h00;
        if (c[7] && !c[3] && c[2])
            m[c[1:0]] = 1'h1;
        if (c[7] && c[3:0] == 4'h3)
            m[4] = 1'h1;
        return m;
    endfunction

    task automatic conclude;
        if (bad_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
        end
    endtask

    // outputs are registered: compare with last edge's expectation
    always @(posedge aclk) begin
        if (busy) quiet = 0;
        else if (quiet < 3) quiet++;
        if (quiet == 3) begin
            chk(conditioned_high_carrier, eh);
            chk(conditioned_low_carrier, el);
            if (ok_r) chk(source_pin_release, er);
        end
        eh = car(hi_q);
        el = car(lo_q);
        er = rel(hi_q) | rel(lo_q);
        ok_r = pwm_unit_pwm_mode == 4'hF;
    end

    // ----------------------------------------
    // axi4-lite master, every wait bounded
    // ----------------------------------------
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic ad = 1'h0, wd = 1'h0;
        busy = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (int n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_bvalid === 1'h1 && ad && wd) begin
                if (a == mcs_pkg::OFS_HIGH_CARRIER) hi_q = d & mcs_pkg::CARRIER_WMASK;
                if (a == mcs_pkg::OFS_LOW_CARRIER) lo_q = d & mcs_pkg::CARRIER_WMASK;
                busy = 1'h0;
                return;
            end
            if (s_axi_awready === 1'h1) ad = 1'h1;
            s_axi_awvalid <= !ad;
            if (s_axi_wready === 1'h1) wd = 1'h1;
            s_axi_wvalid <= !wd;
        end
        bad_count++;
        conclude();
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        logic ad = 1'h0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (int n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_axi_rvalid === 1'h1 && ad) begin
                d = s_axi_rdata[7:0];
                return;
            end
            if (s_axi_arready === 1'h1) ad = 1'h1;
            s_axi_arvalid <= !ad;
        end
        bad_count++;
        conclude();
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'h4D2E2FF1));
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        rd(mcs_pkg::OFS_HIGH_CARRIER, r); chk(r, mcs_pkg::RST_CARRIER);
        rd(mcs_pkg::OFS_MOD_CONTROL, r); chk(r, mcs_pkg::RST_CONTROL);
        rd(mcs_pkg::OFS_MOD_SOURCE, r); chk(r, mcs_pkg::RST_SOURCE);
        // all select codes, random upper bits
        for (int k = 0; k < 32; k++) begin
            v = {4'($urandom), 4'(k)};
            full_mode <= k[4];
            wr(mcs_pkg::OFS_HIGH_CARRIER, v);
            wr(mcs_pkg::OFS_LOW_CARRIER, ~v);
            rd(mcs_pkg::OFS_HIGH_CARRIER, r); chk(r, v & mcs_pkg::CARRIER_WMASK);
            rd(mcs_pkg::OFS_LOW_CARRIER, r); chk(r, ~v & mcs_pkg::CARRIER_WMASK);
            repeat (24) @(posedge aclk);
        end
        wr(mcs_pkg::OFS_MOD_SOURCE, 8'hFF);
        rd(mcs_pkg::OFS_MOD_SOURCE, r); chk(r, mcs_pkg::SOURCE_WMASK);
        chk({modulation_source_pin_disable, 3'h0, modulation_source_select}, mcs_pkg::SOURCE_WMASK);
        wr(mcs_pkg::OFS_MOD_SOURCE, 8'h01);
        // inverted ground: steady one on high
        wr(mcs_pkg::OFS_HIGH_CARRIER, 8'h40);
        wr(mcs_pkg::OFS_LOW_CARRIER, 8'h00);
        wr(mcs_pkg::OFS_MOD_CONTROL, 8'hD0);
        for (int i = 0; i < 8; i++) begin
            v[0] = 1'($urandom);
            modulation_signal <= v[0];
            repeat (4) @(posedge aclk);
            chk(mixed_output, v[0]);
        end
        rd(mcs_pkg::OFS_MOD_CONTROL, r); chk(r, {4'hD, v[0], 3'h0});
        chk({modulator_pin_output_enable, output_slew_limit, output_invert}, 8'h05);
        modulation_signal <= 1'h1;
        wr(mcs_pkg::OFS_MOD_CONTROL, 8'h00);
        repeat (4) @(posedge aclk);
        chk(mixed_output, 8'h00);
        wr(mcs_pkg::OFS_MOD_CONTROL, 8'h80);
        // sync holds a steady carrier until it falls
        for (int s = 0; s < 2; s++) begin
            modulation_signal <= ~s[0];
            wr(mcs_pkg::OFS_HIGH_CARRIER, s[0] ? 8'h00 : 8'h60);
            wr(mcs_pkg::OFS_LOW_CARRIER, s[0] ? 8'h60 : 8'h00);
            repeat (4) @(posedge aclk);
            chk(mixed_output, 8'h01);
            modulation_signal <= s[0];
            repeat (8) @(posedge aclk);
            chk(mixed_output, 8'h01);
            wr(s[0] ? mcs_pkg::OFS_HIGH_CARRIER : mcs_pkg::OFS_LOW_CARRIER, 8'h40);
            wr(s[0] ? mcs_pkg::OFS_LOW_CARRIER : mcs_pkg::OFS_HIGH_CARRIER, 8'h20);
            repeat (4) @(posedge aclk);
            chk(mixed_output, 8'h01);
            modulation_signal <= ~s[0];
            repeat (4) @(posedge aclk);
            chk(mixed_output, 8'h00);
        end
        conclude();
    end
endmodule
